// ### ftsi_pkg.sv
// Purpose: constants and types for the transmit status and interrupt block
// Assumes: one 125 MHz clock, AHB-Lite register access, eight ports
// Notes: register indices are word indices, byte address is four times index
`default_nettype none
package ftsi_pkg;
    localparam int NPORT = 8;
    localparam int PORT_LSB = 9; // 200h index stride per port
    localparam int IDX_MSB = 11;
    // register indices inside one port
    localparam logic [8:0] IDX_WM_SEL = 9'h187;
    localparam logic [8:0] IDX_SYNC_CTRL = 9'h18e;
    localparam logic [8:0] IDX_LAT_MAIN = 9'h190;
    localparam logic [8:0] IDX_LAT_HDLC = 9'h191;
    localparam logic [8:0] IDX_SYNC_STAT = 9'h192;
    localparam logic [8:0] IDX_PEND = 9'h19f;
    localparam logic [8:0] IDX_MASK_MAIN = 9'h1a0;
    localparam logic [8:0] IDX_MASK_HDLC = 9'h1a1;
    localparam logic [8:0] IDX_MASK_SYNC = 9'h1a2;
    localparam logic [8:0] IDX_MODE = 9'h1ae;
    // main latch fields
    localparam int B_FULL = 7;
    localparam int B_EMPTY = 6;
    localparam int B_SLIP = 5;
    localparam int B_SLC = 4;
    localparam int B_DENS = 3;
    localparam int B_MF = 2;
    localparam int B_RESTORE = 1;
    localparam int B_LOST = 0;
    // hdlc latch fields
    localparam int H_DL = 4;
    localparam int H_UDR = 3;
    localparam int H_MEND = 2;
    localparam int H_BWM = 1;
    localparam int H_NF = 0;
    // sync status, sync control and mode fields
    localparam int S_SEARCH = 1;
    localparam int S_DET = 0;
    localparam int C_AUTO_DIS = 1;
    localparam int C_RESYNC = 0;
    localparam int M_T1 = 0;
    localparam int M_ESF = 1;
    localparam int M_SLC = 2;
    localparam int M_LOST = 7;
    localparam logic [7:0] HDLC_BITS = 8'h1f;
    localparam logic [7:0] SYNC_BITS = 8'h01;
    // hdlc fifo
    localparam logic [6:0] FIFO_BYTES = 7'h40;
    localparam logic [6:0] WM_0 = 7'h04;
    localparam logic [6:0] WM_1 = 7'h10;
    localparam logic [6:0] WM_2 = 7'h20;
    localparam logic [6:0] WM_3 = 7'h30;
    // frame counts per multiframe
    localparam logic [6:0] E1_MF_FRAMES = 7'h10;
    localparam logic [6:0] E1_AF_FRAMES = 7'h02;
    localparam logic [6:0] D4_FRAMES = 7'h0c;
    localparam logic [6:0] ESF_FRAMES = 7'h18;
    localparam logic [6:0] SLC_FRAMES = 7'h48;
    // line clock loss timing
    localparam int CLK_NS = 8;
    localparam int T1_LINE_NS = 648;
    localparam int E1_LINE_NS = 488;
    localparam int LOSS_PERIODS = 3;
    localparam logic [7:0] LOSS_T1_CYC = 8'((LOSS_PERIODS * T1_LINE_NS) / CLK_NS);
    localparam logic [7:0] LOSS_E1_CYC = 8'((LOSS_PERIODS * E1_LINE_NS) / CLK_NS);
    localparam int HTRANS_ACTIVE = 1;

    // framer-side inputs of one port, all on CLK
    typedef struct packed {
        logic frame_tick;
        logic elastic_full;
        logic elastic_empty;
        logic pulse_density_violation;
        logic datalink_byte_empty;
        logic message_end;
        logic end_marked;
        logic frame_search_now;
        logic [6:0] fifo_level;
    } ftsi_ev_type;

    typedef struct packed {
        logic [7:0] lat_main;
        logic [7:0] lat_hdlc;
        logic [7:0] lat_sync;
        logic [7:0] mask_main;
        logic [7:0] mask_hdlc;
        logic [7:0] mask_sync;
        logic [1:0] wm_sel;
        logic [1:0] sync_ctrl;
        logic resync_prev;
        logic [2:0] mode;
        logic [6:0] frame_cnt;
        logic prev_bwm;
        logic prev_nf;
        logic [6:0] prev_level;
    } ftsi_port_type;

    typedef struct packed {
        ftsi_port_type [NPORT-1:0] port;
        logic ap_wr;
        logic [IDX_MSB:0] ap_idx;
        logic [31:0] hrdata;
        logic int_n;
        logic [NPORT-1:0] resync_p;
        logic [NPORT-1:0] abort_p;
    } ftsi_top_type;

    typedef struct packed {
        logic [1:0] sync;
        logic prev;
        logic [7:0] cnt;
        logic lost;
        logic lost_set;
        logic restored;
    } ftsi_mon_type;
endpackage
`default_nettype wire

// ### ftsi_evlatch.sv
// Purpose: next value and pending flag of one latched event register
// Assumes: pure combinational, owner holds the latch flops
// Notes: set has priority over a write-one clear in the same cycle
`default_nettype none
module ftsi_evlatch (
    input wire logic [7:0] cur,
    input wire logic [7:0] set,
    input wire logic [7:0] clr,
    input wire logic [7:0] mask,
    output logic [7:0] next_lat,
    output logic pend
);
    // clear first, then or in new events so none is lost
    assign next_lat = (cur & ~clr) | set;
    // only unmasked latched bits count toward the pin
    assign pend = |(cur & mask);
endmodule
`default_nettype wire

// ### ftsi_clkmon.sv
// Purpose: watch one transmit line clock pin for activity
// Assumes: line clock is asynchronous, sampled by two flops first
// Notes: line clock must be well below half the system clock rate
`default_nettype none
module ftsi_clkmon (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_clock,
    input wire logic t1_mode,
    output logic lost,
    output logic lost_set,
    output logic restored
);
    import ftsi_pkg::*;
    ftsi_mon_type s, next_s;
    logic edge_seen; // any transition on the synced clock
    logic [7:0] limit; // silent cycles for three line periods

    assign edge_seen = s.sync[1] ^ s.prev;
    assign limit = t1_mode ? LOSS_T1_CYC : LOSS_E1_CYC;

    // silence counter and loss condition
    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[0], line_clock};
        next_s.prev = s.sync[1];
        next_s.lost_set = 1'b0;
        next_s.restored = 1'b0;
        if (edge_seen) begin
            next_s.cnt = '0;
            next_s.lost = 1'b0;
            next_s.restored = s.lost;
        end else if (s.cnt >= limit) begin
            next_s.lost = 1'b1; // stays while clock is absent
            next_s.lost_set = ~s.lost;
        end else begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    // single register stage for all monitor state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign lost = s.lost;
    assign lost_set = s.lost_set;
    assign restored = s.restored;
endmodule
`default_nettype wire

// ### ftsi_top.sv
// Purpose: transmit event latches, masks and interrupt pin for eight ports
// Assumes: framer inputs are on CLK, line clocks are asynchronous pins
// Notes: zero-wait AHB-Lite slave, word accesses, OKAY only
//
// Design decision made here: the AHB-Lite interface to the registers.
`default_nettype none
module ftsi_top (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [ftsi_pkg::NPORT-1:0] TX_LINE_CLOCK,
    input wire ftsi_pkg::ftsi_ev_type [ftsi_pkg::NPORT-1:0] EVENTS,
    output logic [ftsi_pkg::NPORT-1:0] RESYNC_START,
    output logic [ftsi_pkg::NPORT-1:0] AUTO_RESYNC_DISABLE,
    output logic [ftsi_pkg::NPORT-1:0] ABORT_SEND,
    output logic [ftsi_pkg::NPORT-1:0] LINE_CLOCK_LOST,
    output logic INTERRUPT_OUT_N
);
    import ftsi_pkg::*;

    ftsi_top_type s, next_s; // all block state except the clock monitors
    logic [NPORT-1:0] lost; // real-time clock loss per port
    logic [NPORT-1:0] lost_set; // loss onset pulse
    logic [NPORT-1:0] restored; // clock return pulse
    logic [NPORT-1:0][7:0] set_main, set_hdlc, set_sync;
    logic [NPORT-1:0][7:0] clr_main, clr_hdlc, clr_sync;
    logic [NPORT-1:0][7:0] nxt_main, nxt_hdlc, nxt_sync;
    logic [NPORT-1:0][2:0] pend; // summary bits per port
    logic [NPORT-1:0] mf_hit, af_hit, slc_hit; // frame timing events
    logic [NPORT-1:0] bwm_now, nf_now, udr_hit;
    logic addr_ok; // address inside the mapped window
    logic take; // address phase accepted this edge

    // true on the last frame of a multiframe of len frames
    function automatic logic frame_end(input logic [6:0] cnt, input logic [6:0] len);
        frame_end = (cnt % len) == (len - 7'h01);
    endfunction

    // watermark select to byte threshold
    function automatic logic [6:0] wm_bytes(input logic [1:0] sel);
        case (sel)
            2'b00: wm_bytes = WM_0;
            2'b01: wm_bytes = WM_1;
            2'b10: wm_bytes = WM_2;
            default: wm_bytes = WM_3;
        endcase
    endfunction

    // data-phase write hits register idx of port p
    function automatic logic wr_hit(input ftsi_top_type st, input int p,
                                    input logic [8:0] idx);
        wr_hit = st.ap_wr && (st.ap_idx[IDX_MSB:PORT_LSB] == 3'(p))
                 && (st.ap_idx[PORT_LSB-1:0] == idx);
    endfunction

    assign addr_ok = (HADDR[31:IDX_MSB+3] == '0);
    assign take = HSEL && HREADY && HTRANS[HTRANS_ACTIVE];

    // per-port event sources, monitors and latches
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic t1;
        logic [6:0] cnt;
        assign t1 = s.port[p].mode[M_T1];
        assign cnt = s.port[p].frame_cnt;

        ftsi_clkmon u_mon (
            .clk(CLK),
            .rst_n(RESET_N),
            .line_clock(TX_LINE_CLOCK[p]),
            .t1_mode(t1),
            .lost(lost[p]),
            .lost_set(lost_set[p]),
            .restored(restored[p])
        );

        // multiframe length follows mode and t1 framing
        assign mf_hit[p] = EVENTS[p].frame_tick && (t1 ?
            frame_end(cnt, s.port[p].mode[M_ESF] ? ESF_FRAMES : D4_FRAMES) :
            frame_end(cnt, E1_MF_FRAMES));
        // two e1 frames of 125us make 250us
        assign af_hit[p] = EVENTS[p].frame_tick && !t1
            && frame_end(cnt, E1_AF_FRAMES);
        assign slc_hit[p] = EVENTS[p].frame_tick && t1 && s.port[p].mode[M_SLC]
            && frame_end(cnt, SLC_FRAMES);

        // live fifo conditions from the fill level
        assign bwm_now[p] = EVENTS[p].fifo_level < wm_bytes(s.port[p].wm_sel);
        assign nf_now[p] = EVENTS[p].fifo_level != FIFO_BYTES;
        // fifo ran dry with no message end marked
        assign udr_hit[p] = (s.port[p].prev_level != '0)
            && (EVENTS[p].fifo_level == '0) && !EVENTS[p].end_marked;

        assign set_main[p][B_FULL] = EVENTS[p].elastic_full;
        assign set_main[p][B_EMPTY] = EVENTS[p].elastic_empty;
        assign set_main[p][B_SLIP] = EVENTS[p].elastic_full
            | EVENTS[p].elastic_empty;
        assign set_main[p][B_SLC] = slc_hit[p];
        // bit 3 meaning swaps with the line mode
        assign set_main[p][B_DENS] = t1 ? EVENTS[p].pulse_density_violation
            : af_hit[p];
        assign set_main[p][B_MF] = mf_hit[p];
        assign set_main[p][B_RESTORE] = restored[p];
        assign set_main[p][B_LOST] = lost_set[p];

        assign set_hdlc[p][7:5] = '0;
        assign set_hdlc[p][H_DL] = t1 && EVENTS[p].datalink_byte_empty;
        assign set_hdlc[p][H_UDR] = udr_hit[p];
        assign set_hdlc[p][H_MEND] = EVENTS[p].message_end;
        assign set_hdlc[p][H_BWM] = bwm_now[p] && !s.port[p].prev_bwm;
        assign set_hdlc[p][H_NF] = nf_now[p] && !s.port[p].prev_nf;

        // latched detect re-arms every cycle the search is on
        assign set_sync[p] = {7'h00, EVENTS[p].frame_search_now};

        // write one to clear, data-phase write data
        assign clr_main[p] = wr_hit(s, p, IDX_LAT_MAIN) ? HWDATA[7:0] : '0;
        assign clr_hdlc[p] = wr_hit(s, p, IDX_LAT_HDLC) ? HWDATA[7:0] : '0;
        assign clr_sync[p] = wr_hit(s, p, IDX_SYNC_STAT)
            ? (HWDATA[7:0] & SYNC_BITS) : '0;

        ftsi_evlatch u_main (
            .cur(s.port[p].lat_main),
            .set(set_main[p]),
            .clr(clr_main[p]),
            .mask(s.port[p].mask_main),
            .next_lat(nxt_main[p]),
            .pend(pend[p][0])
        );
        ftsi_evlatch u_hdlc (
            .cur(s.port[p].lat_hdlc),
            .set(set_hdlc[p]),
            .clr(clr_hdlc[p]),
            .mask(s.port[p].mask_hdlc),
            .next_lat(nxt_hdlc[p]),
            .pend(pend[p][1])
        );
        ftsi_evlatch u_sync (
            .cur(s.port[p].lat_sync),
            .set(set_sync[p]),
            .clr(clr_sync[p]),
            .mask(s.port[p].mask_sync),
            .next_lat(nxt_sync[p]),
            .pend(pend[p][2])
        );

        assign AUTO_RESYNC_DISABLE[p] = s.port[p].sync_ctrl[C_AUTO_DIS];
    end

    // next state: latches, control writes, bus phase, pin
    always_comb begin
        logic [IDX_MSB:0] ridx;
        logic [2:0] rp;
        logic [8:0] rr;
        logic [31:0] rd;
        logic any;
        next_s = s;
        ridx = HADDR[IDX_MSB+2:2];
        rp = ridx[IDX_MSB:PORT_LSB];
        rr = ridx[PORT_LSB-1:0];
        rd = '0;
        any = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            next_s.port[p].lat_main = nxt_main[p];
            next_s.port[p].lat_hdlc = nxt_hdlc[p];
            next_s.port[p].lat_sync = nxt_sync[p];
            next_s.port[p].prev_bwm = bwm_now[p];
            next_s.port[p].prev_nf = nf_now[p];
            next_s.port[p].prev_level = EVENTS[p].fifo_level;
            // frame counter wraps at the longest multiframe of the mode
            if (EVENTS[p].frame_tick) begin
                if (frame_end(s.port[p].frame_cnt,
                              s.port[p].mode[M_T1] ? SLC_FRAMES : E1_MF_FRAMES)) begin
                    next_s.port[p].frame_cnt = '0;
                end else begin
                    next_s.port[p].frame_cnt = s.port[p].frame_cnt + 7'h01;
                end
            end
            // control and mask writes in the data phase
            if (wr_hit(s, p, IDX_MASK_MAIN)) begin
                next_s.port[p].mask_main = HWDATA[7:0];
            end
            if (wr_hit(s, p, IDX_MASK_HDLC)) begin
                next_s.port[p].mask_hdlc = HWDATA[7:0] & HDLC_BITS;
            end
            if (wr_hit(s, p, IDX_MASK_SYNC)) begin
                next_s.port[p].mask_sync = HWDATA[7:0] & SYNC_BITS;
            end
            if (wr_hit(s, p, IDX_WM_SEL)) begin
                next_s.port[p].wm_sel = HWDATA[1:0];
            end
            if (wr_hit(s, p, IDX_SYNC_CTRL)) begin
                next_s.port[p].sync_ctrl = HWDATA[1:0];
            end
            if (wr_hit(s, p, IDX_MODE)) begin
                next_s.port[p].mode = HWDATA[2:0];
            end
            // one resync per low-to-high of the trigger bit
            next_s.port[p].resync_prev = s.port[p].sync_ctrl[C_RESYNC];
            next_s.resync_p[p] = s.port[p].sync_ctrl[C_RESYNC]
                && !s.port[p].resync_prev;
            next_s.abort_p[p] = udr_hit[p];
            any = any | (|pend[p]);
        end
        // pin low while any unmasked latch is set
        next_s.int_n = ~any;

        // read data prepared in the address phase
        if (!addr_ok) begin
            rd = '0;
        end else if (rr == IDX_LAT_MAIN) begin
            rd[7:0] = s.port[rp].lat_main;
        end else if (rr == IDX_LAT_HDLC) begin
            rd[7:0] = s.port[rp].lat_hdlc;
        end else if (rr == IDX_SYNC_STAT) begin
            rd[S_DET] = s.port[rp].lat_sync[S_DET];
            rd[S_SEARCH] = EVENTS[rp].frame_search_now;
        end else if (rr == IDX_PEND) begin
            rd[2:0] = pend[rp];
        end else if (rr == IDX_MASK_MAIN) begin
            rd[7:0] = s.port[rp].mask_main;
        end else if (rr == IDX_MASK_HDLC) begin
            rd[7:0] = s.port[rp].mask_hdlc;
        end else if (rr == IDX_MASK_SYNC) begin
            rd[7:0] = s.port[rp].mask_sync;
        end else if (rr == IDX_WM_SEL) begin
            rd[1:0] = s.port[rp].wm_sel;
        end else if (rr == IDX_SYNC_CTRL) begin
            rd[1:0] = s.port[rp].sync_ctrl;
        end else if (rr == IDX_MODE) begin
            rd[2:0] = s.port[rp].mode;
            rd[M_LOST] = lost[rp]; // live condition
        end else begin
            rd = '0; // unmapped reads as zero
        end

        // capture the address phase; idle leaves data untouched
        if (take) begin
            next_s.ap_wr = HWRITE && addr_ok;
            next_s.ap_idx = ridx;
            next_s.hrdata = HWRITE ? s.hrdata : rd;
        end else if (HREADY) begin
            next_s.ap_wr = 1'b0;
        end
    end

    // single register stage; pin idles high
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            s <= '0; // masks and latches clear
            s.int_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign HRDATA = s.hrdata;
    assign HREADYOUT = 1'b1; // never waits
    assign HRESP = 1'b0; // always OKAY
    assign RESYNC_START = s.resync_p;
    assign ABORT_SEND = s.abort_p;
    assign LINE_CLOCK_LOST = lost;
    assign INTERRUPT_OUT_N = s.int_n;
endmodule
`default_nettype wire

// ### ftsi_top_props.sv
// Purpose: port level checks of ftsi_top, watching port 0
// Assumes: HREADY is fed back from HREADYOUT by the bench
// Notes: silence counter saturates, so a long loss keeps the check armed
`default_nettype none
module ftsi_top_props (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [ftsi_pkg::NPORT-1:0] TX_LINE_CLOCK,
    input wire ftsi_pkg::ftsi_ev_type [ftsi_pkg::NPORT-1:0] EVENTS,
    input wire logic [ftsi_pkg::NPORT-1:0] RESYNC_START,
    input wire logic [ftsi_pkg::NPORT-1:0] AUTO_RESYNC_DISABLE,
    input wire logic [ftsi_pkg::NPORT-1:0] ABORT_SEND,
    input wire logic [ftsi_pkg::NPORT-1:0] LINE_CLOCK_LOST,
    input wire logic INTERRUPT_OUT_N
);
    import ftsi_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic lc_q; // last sampled line clock of port 0
    logic [8:0] quiet; // cycles since that line clock moved
    logic wr_ap; // write address phase taken
    assign wr_ap = HSEL && HREADY && HTRANS[1] && HWRITE;
    // silence counter, restarts on any line clock change
    always_ff @(posedge CLK) begin
        lc_q <= TX_LINE_CLOCK[0];
        if (!RESET_N || TX_LINE_CLOCK[0] != lc_q) begin
            quiet <= 9'h000;
        end else if (quiet != 9'h1ff) begin
            quiet <= quiet + 9'h001;
        end
    end
    // fifo drained to empty while no message end was marked
    sequence s_underrun;
        (EVENTS[0].fifo_level != 7'h00)
            ##1 (EVENTS[0].fifo_level == 7'h00 && !EVENTS[0].end_marked);
    endsequence
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready okay");
    a_int_after_reset: assert property ($rose(RESET_N) |-> INTERRUPT_OUT_N [*3])
        else $error("interrupt low right after reset");
    a_lost_not_early: assert property ($rose(LINE_CLOCK_LOST[0]) |-> quiet >= 9'h0b7)
        else $error("clock loss flagged too early");
    a_lost_in_time: assert property (quiet >= 9'h12c |-> LINE_CLOCK_LOST[0])
        else $error("clock loss missing while silent");
    a_restore_on_edge: assert property ($fell(LINE_CLOCK_LOST[0]) |-> quiet <= 9'h006)
        else $error("clock loss cleared without activity");
    a_resync_after_write: assert property (RESYNC_START[0] |->
        $past(wr_ap, 2) || $past(wr_ap, 3) || $past(wr_ap, 4))
        else $error("resync start without a write");
    a_resync_single: assert property (RESYNC_START[0] |=> !RESYNC_START[0])
        else $error("resync start longer than one cycle");
    a_auto_dis_write: assert property ($changed(AUTO_RESYNC_DISABLE[0]) |->
        $past(wr_ap, 2) || $past(wr_ap, 3))
        else $error("auto resync disable moved without a write");
    a_abort_on_underrun: assert property (s_underrun |-> ##[1:3] ABORT_SEND[0])
        else $error("no abort after underrun");
endmodule
`default_nettype wire

// ### ftsi_top_tb.sv
// Purpose: self-checking bench of ftsi_top over its register bus
// Assumes: zero-wait slave, line clocks free running unless stopped
// Notes: fifo level starts full so no stray not-full event after reset
`default_nettype none
module ftsi_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ftsi_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [7:0] lc = 8'h00, lc_run = 8'hff; // line clocks and their enables
    ftsi_ev_type [NPORT-1:0] ev = {NPORT{15'h0040}}; // fifo full, no events
    logic hready, hresp, int_n;
    logic [7:0] rs_go, ard, abort, lost;
    int num_errors = 0, cmp_count = 0, rs_cnt = 0, ab_cnt = 0;
    int wm [4] = '{4, 16, 32, 48};
    ftsi_top DUT (.CLK(clk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .TX_LINE_CLOCK(lc), .EVENTS(ev),
        .RESYNC_START(rs_go), .AUTO_RESYNC_DISABLE(ard), .ABORT_SEND(abort),
        .LINE_CLOCK_LOST(lost), .INTERRUPT_OUT_N(int_n));
    initial begin
        forever #4 clk = ~clk;
    end
    // line clocks, half period of 30 system cycles
    always begin
        repeat (30) @(posedge clk);
        lc <= lc ^ lc_run;
    end
    // count pulses of port 0
    always @(posedge clk) begin
        rs_cnt <= rs_cnt + int'(rs_go[0]);
        ab_cnt <= ab_cnt + int'(abort[0]);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single word transfer; the master never guesses the wait
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    function automatic logic [31:0] ra(input int p, input logic [8:0] idx);
        return 32'((p * 512 + int'(idx)) * 4);
    endfunction
    task automatic wr(input int p, input logic [8:0] idx, input logic [31:0] d);
        bus(1'b1, ra(p, idx), d);
    endtask
    task automatic rdc(input int p, input logic [8:0] idx, input logic [31:0] exp);
        bus(1'b0, ra(p, idx), 32'h0);
        check(rd, exp);
    endtask
    task automatic pulse(input int p, input int b);
        ev[p][b] <= 1'b1;
        @(posedge clk);
        ev[p][b] <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ticks(input int p, input int n);
        repeat (n) pulse(p, 14);
    endtask
    task automatic lvl(input int p, input int v);
        ev[p].fifo_level <= 7'(v);
        repeat (3) @(posedge clk);
    endtask
    task automatic t_reset();
        rdc(0, IDX_LAT_MAIN, 32'h0);
        rdc(0, IDX_LAT_HDLC, 32'h0);
        rdc(0, IDX_PEND, 32'h0);
        rdc(0, IDX_MASK_HDLC, 32'h0);
        bus(1'b1, 32'h0010_0000 | ra(0, IDX_MASK_MAIN), 32'hff);
        rdc(0, IDX_MASK_MAIN, 32'h0);
        check(int_n, 1'b1);
    endtask
    // masked then unmasked elastic events on port 3
    task automatic t_elastic();
        pulse(3, 12);
        rdc(3, IDX_LAT_MAIN, 32'h60);
        check(int_n, 1'b1);
        wr(3, IDX_MASK_MAIN, 32'h80);
        pulse(3, 13);
        rdc(3, IDX_LAT_MAIN, 32'he0);
        check(int_n, 1'b0);
        rdc(3, IDX_PEND, 32'h1);
        wr(3, IDX_LAT_MAIN, 32'h60);
        rdc(3, IDX_LAT_MAIN, 32'h80);
        wr(3, IDX_LAT_MAIN, 32'h80);
        rdc(3, IDX_PEND, 32'h0);
        check(int_n, 1'b1);
    endtask
    // every watermark code, then underrun with and without message end
    task automatic t_hdlc();
        wr(0, IDX_MODE, 32'h1);
        foreach (wm[i]) begin
            wr(0, IDX_WM_SEL, 32'(i));
            lvl(0, wm[i]);
            rdc(0, IDX_LAT_HDLC, 32'h1);
            lvl(0, wm[i] - 1);
            rdc(0, IDX_LAT_HDLC, 32'h3);
            wr(0, IDX_LAT_HDLC, 32'h1f);
            lvl(0, 64);
        end
        lvl(0, 5);
        wr(0, IDX_LAT_HDLC, 32'h1f);
        pulse(0, 9);
        pulse(0, 10);
        lvl(0, 0);
        rdc(0, IDX_LAT_HDLC, 32'h1c);
        wr(0, IDX_MASK_HDLC, 32'h8);
        rdc(0, IDX_PEND, 32'h2);
        check(32'(ab_cnt), 32'h1);
        wr(0, IDX_LAT_HDLC, 32'h1f);
        lvl(0, 5);
        ev[0].end_marked <= 1'b1;
        lvl(0, 0);
        rdc(0, IDX_LAT_HDLC, 32'h0);
        check(32'(ab_cnt), 32'h1);
        ev[0].end_marked <= 1'b0;
    endtask
    // e1 align and multiframe, then t1 d4, slc and esf on port 2
    task automatic t_frames();
        ticks(2, 15);
        rdc(2, IDX_LAT_MAIN, 32'h08);
        wr(2, IDX_LAT_MAIN, 32'hff);
        ticks(2, 1);
        rdc(2, IDX_LAT_MAIN, 32'h0c);
        wr(2, IDX_MODE, 32'h5);
        wr(2, IDX_LAT_MAIN, 32'hff);
        ticks(2, 11);
        pulse(2, 11);
        rdc(2, IDX_LAT_MAIN, 32'h08);
        wr(2, IDX_LAT_MAIN, 32'hff);
        ticks(2, 1);
        rdc(2, IDX_LAT_MAIN, 32'h04);
        wr(2, IDX_LAT_MAIN, 32'hff);
        ticks(2, 60);
        rdc(2, IDX_LAT_MAIN, 32'h14);
        wr(2, IDX_MODE, 32'h3);
        wr(2, IDX_LAT_MAIN, 32'hff);
        ticks(2, 23);
        rdc(2, IDX_LAT_MAIN, 32'h00);
        ticks(2, 1);
        rdc(2, IDX_LAT_MAIN, 32'h04);
    endtask
    task automatic t_sync();
        ev[0].frame_search_now <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(0, IDX_SYNC_STAT, 32'h3);
        wr(0, IDX_MASK_SYNC, 32'h1);
        rdc(0, IDX_PEND, 32'h4);
        ev[0].frame_search_now <= 1'b0;
        wr(0, IDX_SYNC_STAT, 32'h1);
        rdc(0, IDX_SYNC_STAT, 32'h0);
        rdc(0, IDX_PEND, 32'h0);
    endtask
    task automatic t_resync();
        wr(0, IDX_SYNC_CTRL, 32'h2);
        repeat (3) @(posedge clk);
        check(ard[0], 1'b1);
        foreach (wm[i]) wr(0, IDX_SYNC_CTRL, 32'(8'hbb >> (2 * i)) & 32'h3);
        wr(0, IDX_SYNC_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        check(32'(rs_cnt), 32'h2);
        check(ard[0], 1'b0);
    endtask
    // port 0 line clock stops, latch cleared during the fault, clock returns
    task automatic t_loss();
        wr(0, IDX_LAT_MAIN, 32'hff);
        wr(0, IDX_MASK_MAIN, 32'h01);
        lc_run[0] <= 1'b0;
        repeat (300) @(posedge clk);
        check(lost[0], 1'b1);
        check(int_n, 1'b0);
        wr(0, IDX_LAT_MAIN, 32'h01);
        rdc(0, IDX_LAT_MAIN, 32'h0);
        check(lost[0], 1'b1);
        check(int_n, 1'b1);
        lc_run[0] <= 1'b1;
        repeat (40) @(posedge clk);
        check(lost[0], 1'b0);
        rdc(0, IDX_LAT_MAIN, 32'h2);
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200us;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_elastic();
        t_hdlc();
        t_frames();
        t_sync();
        t_resync();
        t_loss();
        end_of_test();
    end
endmodule
bind ftsi_top ftsi_top_props u_props (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .TX_LINE_CLOCK(TX_LINE_CLOCK), .EVENTS(EVENTS),
    .RESYNC_START(RESYNC_START), .AUTO_RESYNC_DISABLE(AUTO_RESYNC_DISABLE),
    .ABORT_SEND(ABORT_SEND), .LINE_CLOCK_LOST(LINE_CLOCK_LOST),
    .INTERRUPT_OUT_N(INTERRUPT_OUT_N));
`default_nettype wire
